/* File: logic/hvio_pkg.sv */
// constants shared by the wake / hardware-id / high-voltage i/o pin logic
// assumes a 25 MHz core clock and an apb register bus with 32-bit data
package hvio_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS        = 40;
  localparam int FLT_SHORT_NS  = 15000;
  localparam int FLT_LONG_NS   = 65000;
  localparam int FLT_SHORT_CYC = (FLT_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int FLT_LONG_CYC  = (FLT_LONG_NS + CLK_NS - 1) / CLK_NS;
  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_ID   = 8'h00; // location_id_ctrl_reg
  localparam logic [7:0] OFS_WCFG = 8'h04;
  localparam logic [7:0] OFS_FLAG = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_SAFE = 8'h14; // safety_outputs_reg
  localparam logic [7:0] OFS_MODE = 8'h18;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ID_STRIDE = 8;  // one byte per wake/id pin
  localparam int ID_EN_B   = 0;
  localparam int ID_PU_B   = 1;
  localparam int ID_PD_B   = 2;
  localparam int ID_TH_B   = 3;
  localparam int ID_HI_B   = 4;
  localparam int WK_CFG_B  = 0;  // two bits per wake pin
  localparam int HV_CFG_B  = 4;
  localparam int WK_FLT_B  = 8;  // one bit per wake pin
  localparam int HV_FLT_B  = 10;
  localparam int FL_WK_B   = 0;  // two flags
  localparam int FL_HV_B   = 2;
  localparam int FL_WAKE_B = 3;
  localparam int FLAG_W    = 4;
  localparam int SF_GPO_B  = 0;
  localparam int SF_ASR_B  = 1;
  localparam int SF_REL_B  = 2;
  localparam int HV_HI_B   = 3;
  localparam int HV_LO_B   = 4;
  localparam int SF_DRV_B  = 5;
  localparam int HV_LVL_B  = 6;
  localparam int ST_WK_B   = 0;
  localparam int ST_HV_B   = 2;
  localparam int ST_SNS_B  = 3;
  localparam int ST_MODE_B = 4;
  localparam int MD_LOW_POWER_ON_MODE_B = 0;
  localparam int MD_OFF_B  = 1;
  localparam int MD_NORM_B = 2;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] ID_RST   = 16'h0000;
  localparam logic [10:0] WCFG_RST = 11'h000;
  localparam logic [3:0]  MASK_RST = 4'h0;
  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] WCFG_OFF  = 2'h0;
  localparam logic [1:0] WCFG_HIGH = 2'h1;
  localparam logic [1:0] WCFG_LOW  = 2'h2;
  localparam logic [1:0] WCFG_MSEL = 2'h3; // mode selection, hv pin only
  localparam logic [1:0] PULL_OFF  = 2'h0;
  localparam logic [1:0] PULL_DN   = 2'h1;
  localparam logic [1:0] PULL_UP   = 2'h2;
  localparam logic [1:0] PULL_REP  = 2'h3;
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_LOW_POWER_ON_MODE   = 2'h1,
    MODE_LPOFF  = 2'h3
  } mode_e;
endpackage

/* File: logic/pin_filter.sv */
// two-stage synchroniser plus deglitch filter for one high-voltage input
// assumes the pin is asynchronous and long_sel comes from the core clock
`timescale 1ns/10ps
`default_nettype none
module pin_filter
  import hvio_pkg::*;
#(
  parameter int SHORT_CYC = FLT_SHORT_CYC,
  parameter int LONG_CYC  = FLT_LONG_CYC,
  parameter int CNT_W     = 11
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // pin and filter choice
  input  wire logic pin_async,
  input  wire logic long_sel,
  // filtered level
  output var  logic level_r
);
  // refuse counters too narrow for the longest filter time
  if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC || LONG_CYC > (2 ** CNT_W)) begin : g_chk
    $error("pin_filter: counter width cannot hold filter time");
  end

  logic             sync_a_r;
  logic             sync_b_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] limit;

  // long and short filter end counts
  assign limit = long_sel ? CNT_W'(LONG_CYC - 1) : CNT_W'(SHORT_CYC - 1);

  // synchroniser: only sync_b_r reads sync_a_r
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync_a_r <= 1'b0;
      sync_b_r <= 1'b0;
    end else begin
      sync_a_r <= pin_async;
      sync_b_r <= sync_a_r;
    end
  end

  // a new level must hold for the whole filter time before it is passed on
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_r   <= '0;
      level_r <= 1'b0;
    end else if (sync_b_r == level_r) begin
      cnt_r <= '0;
    end else if (cnt_r >= limit) begin
      cnt_r   <= '0;
      level_r <= sync_b_r;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  a_filter_hold: assert property (@(posedge clock) disable iff (reset)
    $changed(level_r) |-> $past(cnt_r) >= $past(limit))
    else $error("filtered level changed before filter time");
endmodule // pin_filter
`default_nettype wire

/* File: logic/wake_hwid_hv_io_pin_logic.sv */
// wake / hardware-id pins, safe-state pin reuse and high-voltage i/o pin
// assumes an apb master on CLOCK; otp and slot signals come from CLOCK logic
//
// What this block does
// - id current sources act only in normal mode with the pin's id enable set.
// - software switches id pull sources on and off and reads the filtered pin state.
// - each id pin has a threshold select and a high-current select output.
// - the safe pin is driven by assert/release bits only with otp enable 0 and gpo 1.
// - in normal mode an hv input change sets its flag unless masked.
// - in low-power modes the hv pin wakes on the level its config selects.
// - in mode selection an hv fall goes normal to low_power_on_mode, a rise goes back.
// - deglitch time is 15 us with its select bit 0 and 65 us with it 1.
// - otp pull setting is off, pulldown, pullup or repeater following the level.
// - in otp output mode the hv pin follows drive-high and drive-low bits.
// - at power-up a slotted output takes its default at otp load, inverts at slot start.
// - at power-down a slotted output returns to default at its slot start.
// - in normal mode wake pin changes set flags; in low power they wake by level.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module wake_hwid_hv_io_pin_logic
  import hvio_pkg::*;
(
  // clock and reset
  input  wire logic       CLOCK,
  input  wire logic       RESET,
  // apb slave
  input  wire logic       PSEL,
  input  wire logic       PENABLE,
  input  wire logic       PWRITE,
  input  wire logic [7:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic       PREADY,
  output var  logic       PSLVERR,
  output var  logic       IRQ,
  // wake/id pins
  input  wire logic [1:0] WAKE_ID_PIN,
  output var  logic [1:0] ID_CURRENT_SOURCE_PU,
  output var  logic [1:0] ID_CURRENT_SOURCE_PD,
  output var  logic [1:0] ID_THRESHOLD_SELECT,
  output var  logic [1:0] ID_HIGH_CURRENT_SELECT,
  // safe-state pin
  input  wire logic       SAFE_STATE_PIN_IN,
  output var  logic       SAFE_STATE_PIN_OUT,
  output var  logic       SAFE_STATE_PIN_OE,
  // high-voltage i/o pin
  input  wire logic       HV_IO_PIN_IN,
  output var  logic       HV_IO_PIN_OUT,
  output var  logic       HV_IO_PIN_OE,
  output var  logic       HV_PULLUP_EN,
  output var  logic       HV_PULLDOWN_EN,
  // otp mirror and power sequencer
  input  wire logic       SAFE_PIN_OTP_ENABLE,
  input  wire logic [1:0] HV_PIN_PULL_CONFIG,
  input  wire logic       HV_PIN_OUTPUT_OTP,
  input  wire logic       HV_PIN_DEFAULT_LEVEL,
  input  wire logic [1:0] HV_PIN_SLOT_ASSIGN,
  input  wire logic       OTP_LOADED,
  input  wire logic [2:0] SLOT_START,
  input  wire logic       POWER_DOWN,
  // device mode
  output var  logic [1:0] DEVICE_MODE
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  mode_e             mode_r;
  mode_e             mode_nxt;
  logic [15:0]       id_r;
  logic [10:0]       wcfg_r;
  logic [FLAG_W-1:0] flag_r;
  logic [FLAG_W-1:0] mask_r;
  logic [FLAG_W-1:0] flag_set;
  logic [FLAG_W-1:0] flag_clr;
  logic              gpo_r;
  logic              safe_drv_r;
  logic              safe_a_r;
  logic              safe_b_r;
  logic              hv_lvl_r;
  logic              otp_seen_r;
  logic [2:0]        filt;
  logic [2:0]        filt_d_r;
  logic [2:0]        chg;
  logic [31:0]       rdata;
  logic              mapped;
  logic              setup;
  logic              wr;
  logic              normal;
  logic              lp_wake;
  logic              msel_fall;
  logic              msel_rise;
  logic              slot_hit;
  logic [1:0]        hv_cfg;
  logic [2:0]        pins;

  // ---------------------------------------------------------------
  // apb slave: zero wait, answer in the first access cycle
  // ---------------------------------------------------------------
  assign setup = PSEL & ~PENABLE;
  assign wr    = PSEL & PENABLE & PREADY & PWRITE;
  assign mapped = (PADDR == OFS_ID) | (PADDR == OFS_WCFG) | (PADDR == OFS_FLAG)
                | (PADDR == OFS_MASK) | (PADDR == OFS_STAT) | (PADDR == OFS_SAFE)
                | (PADDR == OFS_MODE);

  // read mux; unmapped and write-only locations read zero
  always_comb begin
    rdata = 32'h0000_0000;
    case (PADDR)
      OFS_ID:   rdata[15:0] = id_r;
      OFS_WCFG: rdata[10:0] = wcfg_r;
      OFS_FLAG: rdata[FLAG_W-1:0] = flag_r;
      OFS_MASK: rdata[FLAG_W-1:0] = mask_r;
      OFS_STAT: begin
        rdata[ST_WK_B +: 2]   = filt[1:0];
        rdata[ST_HV_B]        = filt[2];
        rdata[ST_SNS_B]       = safe_b_r;
        rdata[ST_MODE_B +: 2] = mode_r;
      end
      OFS_SAFE: begin
        rdata[SF_GPO_B] = gpo_r;
        rdata[SF_DRV_B] = safe_drv_r;
        rdata[HV_LVL_B] = hv_lvl_r;
      end
      default: rdata = 32'h0000_0000;
    endcase
  end

  // answer registers
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup & ~mapped;
      PRDATA  <= (setup & ~PWRITE) ? rdata : 32'h0000_0000;
    end
  end

  // software configuration registers
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      id_r   <= ID_RST;
      wcfg_r <= WCFG_RST;
      mask_r <= MASK_RST;
      gpo_r  <= 1'b0;
    end else if (wr) begin
      if (PADDR == OFS_ID)   id_r   <= PWDATA[15:0];
      if (PADDR == OFS_WCFG) wcfg_r <= PWDATA[10:0];
      if (PADDR == OFS_MASK) mask_r <= PWDATA[FLAG_W-1:0];
      if (PADDR == OFS_SAFE) gpo_r  <= PWDATA[SF_GPO_B];
    end
  end

  // ---------------------------------------------------------------
  // pin filters: index 0,1 wake/id pins, 2 the hv pin
  // ---------------------------------------------------------------
  // one vector, so every filter index selects a real pin
  assign pins = {HV_IO_PIN_IN, WAKE_ID_PIN};
  for (genvar i = 0; i < 3; i++) begin : g_flt
    pin_filter u_flt (
      .clock     (CLOCK),
      .reset     (RESET),
      .pin_async (pins[i]),
      .long_sel  (wcfg_r[WK_FLT_B + i]),
      .level_r   (filt[i])
    );
  end

  // edge detection on filtered levels
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      filt_d_r <= 3'h0;
    end else begin
      filt_d_r <= filt;
    end
  end

  assign chg       = filt ^ filt_d_r;
  assign normal    = (mode_r == MODE_NORMAL);
  assign hv_cfg    = wcfg_r[HV_CFG_B +: 2];
  assign msel_fall = ~HV_PIN_OUTPUT_OTP & (hv_cfg == WCFG_MSEL) & filt_d_r[2] & ~filt[2];
  assign msel_rise = ~HV_PIN_OUTPUT_OTP & (hv_cfg == WCFG_MSEL) & ~filt_d_r[2] & filt[2];

  // level match for one wake configuration
  function automatic logic lvl_hit(input logic [1:0] cfg, input logic lvl);
    lvl_hit = ((cfg == WCFG_HIGH) & lvl) | ((cfg == WCFG_LOW) & ~lvl);
  endfunction

  // low-power wake by level on any enabled source
  assign lp_wake = ~normal & (lvl_hit(wcfg_r[WK_CFG_B +: 2], filt[0])
                 | lvl_hit(wcfg_r[WK_CFG_B + 2 +: 2], filt[1])
                 | (~HV_PIN_OUTPUT_OTP & lvl_hit(hv_cfg, filt[2])));

  // ---------------------------------------------------------------
  // flags and interrupt; a set in the clearing cycle wins
  // ---------------------------------------------------------------
  always_comb begin
    flag_set = '0;
    flag_set[FL_WK_B +: 2] = {2{normal}} & chg[1:0] & ~mask_r[FL_WK_B +: 2];
    flag_set[FL_HV_B] = normal & ~HV_PIN_OUTPUT_OTP & chg[2] & ~mask_r[FL_HV_B];
    flag_set[FL_WAKE_B] = lp_wake;
    flag_clr = (wr && PADDR == OFS_FLAG) ? PWDATA[FLAG_W-1:0] : '0;
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      flag_r <= '0;
      IRQ    <= 1'b0;
    end else begin
      flag_r <= (flag_r & ~flag_clr) | flag_set;
      IRQ    <= |(flag_r & ~mask_r);
    end
  end

  // ---------------------------------------------------------------
  // device mode
  // ---------------------------------------------------------------
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_NORMAL: begin
        if (wr && PADDR == OFS_MODE && PWDATA[MD_OFF_B]) mode_nxt = MODE_LPOFF;
        else if (msel_fall) mode_nxt = MODE_LOW_POWER_ON_MODE;
        else if (wr && PADDR == OFS_MODE && PWDATA[MD_LOW_POWER_ON_MODE_B]) mode_nxt = MODE_LOW_POWER_ON_MODE;
      end
      MODE_LOW_POWER_ON_MODE: begin
        if (lp_wake | msel_rise) mode_nxt = MODE_NORMAL;
        else if (wr && PADDR == OFS_MODE && PWDATA[MD_NORM_B]) mode_nxt = MODE_NORMAL;
      end
      MODE_LPOFF: begin
        if (lp_wake) mode_nxt = MODE_NORMAL;
      end
      default: mode_nxt = MODE_NORMAL;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      mode_r      <= MODE_NORMAL;
      DEVICE_MODE <= MODE_NORMAL;
    end else begin
      mode_r      <= mode_nxt;
      DEVICE_MODE <= mode_nxt;
    end
  end

  // ---------------------------------------------------------------
  // hardware-id current sources; dropped one cycle after normal mode ends
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      ID_CURRENT_SOURCE_PU   <= 2'h0;
      ID_CURRENT_SOURCE_PD   <= 2'h0;
      ID_THRESHOLD_SELECT    <= 2'h0;
      ID_HIGH_CURRENT_SELECT <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        ID_CURRENT_SOURCE_PU[i] <= normal & id_r[i*ID_STRIDE+ID_EN_B]
                                 & id_r[i*ID_STRIDE+ID_PU_B];
        ID_CURRENT_SOURCE_PD[i] <= normal & id_r[i*ID_STRIDE+ID_EN_B]
                                 & id_r[i*ID_STRIDE+ID_PD_B];
        ID_THRESHOLD_SELECT[i]    <= id_r[i*ID_STRIDE+ID_TH_B];
        ID_HIGH_CURRENT_SELECT[i] <= id_r[i*ID_STRIDE+ID_HI_B];
      end
    end
  end

  // ---------------------------------------------------------------
  // safe-state pin as extra id input
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      safe_a_r <= 1'b0;
      safe_b_r <= 1'b0;
    end else begin
      safe_a_r <= SAFE_STATE_PIN_IN;
      safe_b_r <= safe_a_r;
    end
  end

  // open drain: driving means pulling low; release wins over assert
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      safe_drv_r         <= 1'b0;
      SAFE_STATE_PIN_OE  <= 1'b0;
      SAFE_STATE_PIN_OUT <= 1'b0;
    end else begin
      if (SAFE_PIN_OTP_ENABLE | ~gpo_r) safe_drv_r <= 1'b0;
      else if (wr && PADDR == OFS_SAFE && PWDATA[SF_REL_B]) safe_drv_r <= 1'b0;
      else if (wr && PADDR == OFS_SAFE && PWDATA[SF_ASR_B]) safe_drv_r <= 1'b1;
      SAFE_STATE_PIN_OE  <= safe_drv_r & ~SAFE_PIN_OTP_ENABLE & gpo_r;
      SAFE_STATE_PIN_OUT <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // hv pin as open-drain output and its pulls
  // ---------------------------------------------------------------
  always_comb begin
    case (HV_PIN_SLOT_ASSIGN)
      2'h1:    slot_hit = SLOT_START[0];
      2'h2:    slot_hit = SLOT_START[1];
      2'h3:    slot_hit = SLOT_START[2];
      default: slot_hit = 1'b0;
    endcase
  end

  // sequencing events take priority over software drive commands
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      otp_seen_r <= 1'b0;
      hv_lvl_r   <= 1'b1;
    end else begin
      otp_seen_r <= otp_seen_r | OTP_LOADED;
      if (OTP_LOADED & ~otp_seen_r) hv_lvl_r <= HV_PIN_DEFAULT_LEVEL;
      else if (otp_seen_r & slot_hit & ~POWER_DOWN) hv_lvl_r <= ~HV_PIN_DEFAULT_LEVEL;
      else if (otp_seen_r & slot_hit) hv_lvl_r <= HV_PIN_DEFAULT_LEVEL;
      else if (wr && PADDR == OFS_SAFE && PWDATA[HV_HI_B]) hv_lvl_r <= 1'b1;
      else if (wr && PADDR == OFS_SAFE && PWDATA[HV_LO_B]) hv_lvl_r <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      HV_IO_PIN_OE   <= 1'b0;
      HV_IO_PIN_OUT  <= 1'b0;
      HV_PULLUP_EN   <= 1'b0;
      HV_PULLDOWN_EN <= 1'b0;
    end else begin
      HV_IO_PIN_OE  <= HV_PIN_OUTPUT_OTP & ~hv_lvl_r;
      HV_IO_PIN_OUT <= 1'b0;
      case (HV_PIN_PULL_CONFIG)
        PULL_DN: begin
          HV_PULLUP_EN   <= 1'b0;
          HV_PULLDOWN_EN <= 1'b1;
        end
        PULL_UP: begin
          HV_PULLUP_EN   <= 1'b1;
          HV_PULLDOWN_EN <= 1'b0;
        end
        PULL_REP: begin
          HV_PULLUP_EN   <= filt[2];
          HV_PULLDOWN_EN <= ~filt[2];
        end
        default: begin
          HV_PULLUP_EN   <= 1'b0;
          HV_PULLDOWN_EN <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  sequence s_hv_fall_msel;
    normal && msel_fall;
  endsequence
  sequence s_in_low_power_on_mode;
    mode_r == MODE_LOW_POWER_ON_MODE [*2];
  endsequence

  a_id_gate: assert property (ID_CURRENT_SOURCE_PU[0] |->
    $past(normal) && $past(id_r[ID_EN_B])) else $error("id source active outside normal");
  a_id_pd: assert property ($rose(id_r[ID_STRIDE+ID_PD_B]) && id_r[ID_STRIDE+ID_EN_B]
    && normal |=> ID_CURRENT_SOURCE_PD[1])
    else $error("id pulldown not applied");
  a_id_sel: assert property (##1 ID_HIGH_CURRENT_SELECT[0] == $past(id_r[ID_HI_B]))
    else $error("high current select mismatch");
  a_safe_drive: assert property (SAFE_STATE_PIN_OE |->
    $past(~SAFE_PIN_OTP_ENABLE) && $past(gpo_r, 2)) else $error("safe pin driven while unusable");
  a_hv_flag: assert property (normal && chg[2] && !HV_PIN_OUTPUT_OTP && !mask_r[FL_HV_B]
    |=> flag_r[FL_HV_B]) else $error("hv change flag not set");
  a_wk_flag: assert property (normal && chg[0] && !mask_r[FL_WK_B] |=> flag_r[FL_WK_B])
    else $error("wake change flag not set");
  a_lp_wake: assert property (mode_r == MODE_LPOFF && !HV_PIN_OUTPUT_OTP && hv_cfg == WCFG_HIGH
    && filt[2] |=> normal && flag_r[FL_WAKE_B]) else $error("hv level wake missed");
  a_msel_fall: assert property (s_hv_fall_msel |=> mode_r == MODE_LOW_POWER_ON_MODE)
    else $error("mode select fall ignored");
  a_msel_rise: assert property (s_in_low_power_on_mode ##0 msel_rise |=> normal ##1 DEVICE_MODE == MODE_NORMAL)
    else $error("mode select rise ignored");
  a_repeater: assert property (HV_PIN_PULL_CONFIG == PULL_REP |=>
    HV_PULLUP_EN == $past(filt[2]) && HV_PULLDOWN_EN != HV_PULLUP_EN) else $error("repeater pull wrong");
  a_slot_up: assert property (otp_seen_r && slot_hit && !POWER_DOWN && !OTP_LOADED |=>
    hv_lvl_r == !$past(HV_PIN_DEFAULT_LEVEL)) else $error("slot start did not invert");
  a_slot_down: assert property (otp_seen_r && slot_hit && POWER_DOWN |=>
    hv_lvl_r == $past(HV_PIN_DEFAULT_LEVEL) ##1
    HV_IO_PIN_OE == ($past(HV_PIN_OUTPUT_OTP) && !$past(hv_lvl_r)))
    else $error("power-down default not restored");
  a_flag_sticky: assert property (flag_r[FL_HV_B] && !flag_clr[FL_HV_B] |=> flag_r[FL_HV_B])
    else $error("change flag lost");
endmodule // wake_hwid_hv_io_pin_logic
`default_nettype wire

/* File: sim/harness_model.sv */
// harness on the pin side: external pull-ups on the open-drain hv and safe lines
// assumes the bench sets the level that the far device would give the hv line
`timescale 1ns/10ps
`default_nettype none
module harness_model (
  // from bench and design
  input  wire logic hv_ext,
  input  wire logic hv_oe,
  input  wire logic safe_oe,
  // resolved line levels
  output var  logic hv_line,
  output var  logic safe_line
);
  // open drain: a pull-up holds the line high unless someone pulls it low
  always_comb hv_line = hv_ext & ~hv_oe;
  // safe line is biased high by a resistor, so the sense bit reads the drive
  always_comb safe_line = ~safe_oe;
endmodule // harness_model
`default_nettype wire

/* File: sim/test_wake_hwid_hv_io_pin_logic.sv */
// bench for the wake / id / hv pin logic, one task per scenario
// assumes zero-wait apb and the filter counts held in the package
`timescale 1ns/10ps
`default_nettype none
module test_wake_hwid_hv_io_pin_logic
  import hvio_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic CLOCK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, IRQ, e;
  logic [7:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, q;
  logic [1:0] PU, PD, TH, HI, DEVICE_MODE, pull = 0, slot = 0, wk = 0;
  logic hv_ext = 0, hv_line, safe_line, SOUT, SOE, HOUT, HOE, PUE, PDE;
  logic out_otp = 0, loaded = 0, pdn = 0, otp_en = 0, dflt = 0;
  logic [2:0] slot_start = 0;
  int bad_count = 0, compares = 0, cyc = 0;
  localparam int F = FLT_SHORT_CYC + 8;
  always #20 CLOCK = ~CLOCK;
  harness_model pins (.hv_ext(hv_ext), .hv_oe(HOE), .safe_oe(SOE), .hv_line(hv_line),
    .safe_line(safe_line));
  wake_hwid_hv_io_pin_logic dut (.CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ), .WAKE_ID_PIN(wk),
    .ID_CURRENT_SOURCE_PU(PU), .ID_CURRENT_SOURCE_PD(PD), .ID_THRESHOLD_SELECT(TH),
    .ID_HIGH_CURRENT_SELECT(HI), .SAFE_STATE_PIN_IN(safe_line), .SAFE_STATE_PIN_OUT(SOUT),
    .SAFE_STATE_PIN_OE(SOE), .HV_IO_PIN_IN(hv_line), .HV_IO_PIN_OUT(HOUT),
    .HV_IO_PIN_OE(HOE), .HV_PULLUP_EN(PUE), .HV_PULLDOWN_EN(PDE),
    .SAFE_PIN_OTP_ENABLE(otp_en), .HV_PIN_PULL_CONFIG(pull), .HV_PIN_OUTPUT_OTP(out_otp),
    .HV_PIN_DEFAULT_LEVEL(dflt), .HV_PIN_SLOT_ASSIGN(slot), .OTP_LOADED(loaded),
    .SLOT_START(slot_start), .POWER_DOWN(pdn), .DEVICE_MODE(DEVICE_MODE));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // a hung handshake or filter lands here instead of running forever
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    PSEL <= 1; PENABLE <= 0; PWRITE <= wr; PADDR <= a; PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1;
    @(posedge CLOCK);
    while (PREADY !== 1'b1) begin
      @(posedge CLOCK);
    end
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 0; PENABLE <= 0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reg();
    apb(0, 8'h1c, 0); chk(32'(e), 1); chk(q, 0);
  endtask
  // pin 1 asks for its pull-up without its enable, so it must stay off
  task automatic t_id();
    apb(1, OFS_ID, 32'ha13); wt(2);
    chk(32'(PU), 1);
    chk(32'(HI), 1);
    chk(32'(TH), 2);
    apb(1, OFS_ID, 32'h500); wt(2); chk(32'(PD), 2);
    apb(0, OFS_STAT, 0); chk(32'(q[1:0]), 0);
  endtask
  task automatic t_safe();
    apb(1, OFS_SAFE, 32'h1); apb(0, OFS_STAT, 0); chk(32'(q[3]), 1);
    apb(1, OFS_SAFE, 32'h3); wt(3); chk(32'(SOE), 1);
    wt(4); apb(0, OFS_STAT, 0); chk(32'(q[3]), 0);
    apb(1, OFS_SAFE, 32'h5); wt(3); chk(32'(SOE), 0);
    otp_en <= 1; apb(1, OFS_SAFE, 32'h3); wt(3); chk(32'(SOE), 0);
    otp_en <= 0; chk(32'(SOUT), 0);
  endtask
  // wake pin change in normal mode, then a level wake out of low-power off
  task automatic t_wake();
    wk <= 2'h1; wt(F);
    apb(0, OFS_STAT, 0); chk(32'(q[1:0]), 1);
    apb(0, OFS_FLAG, 0); chk(q, 32'h1);
    apb(1, OFS_FLAG, 32'h1); apb(1, OFS_WCFG, 32'h10); apb(1, OFS_MODE, 32'h2); wt(2);
    chk(32'(DEVICE_MODE), 3);
    hv_ext <= 1; wt(F); chk(32'(DEVICE_MODE), 0);
    apb(0, OFS_FLAG, 0); chk(q, 32'h8);
    apb(1, OFS_FLAG, 32'hf);
  endtask
  task automatic t_flag();
    pull <= PULL_REP; hv_ext <= 1; wt(F);
    chk(32'(PUE), 1);
    apb(0, OFS_FLAG, 0); chk(q, 32'h4);
    wt(2); chk(32'(IRQ), 1);
    apb(1, OFS_FLAG, 32'h4); wt(2); chk(32'(IRQ), 0);
    apb(1, OFS_MASK, 32'h4); hv_ext <= 0; wt(F);
    chk(32'(PDE), 1);
    apb(0, OFS_FLAG, 0); chk(q, 0);
  endtask
  // the long filter must still hold the old level after the short time
  task automatic t_msel();
    apb(1, OFS_WCFG, 32'h30); hv_ext <= 1; wt(F); hv_ext <= 0; wt(F);
    chk(32'(DEVICE_MODE), 1);
    chk(32'(PD), 0);
    hv_ext <= 1; wt(F); chk(32'(DEVICE_MODE), 0);
    apb(1, OFS_WCFG, 32'h430); hv_ext <= 0; wt(F);
    chk(32'(DEVICE_MODE), 0);
    wt(FLT_LONG_CYC - FLT_SHORT_CYC); chk(32'(DEVICE_MODE), 1);
  endtask
  task automatic t_out();
    out_otp <= 1; apb(1, OFS_SAFE, 32'h10); wt(3); chk(32'(HOE), 1);
    apb(1, OFS_SAFE, 32'h08); wt(3); chk(32'(HOE), 0);
    slot <= 2'h1; loaded <= 1; wt(1); loaded <= 0; wt(3); chk(32'(HOE), 1);
    slot_start <= 3'h1; wt(1); slot_start <= 0; wt(3); chk(32'(HOE), 0);
    pdn <= 1; slot_start <= 3'h1; wt(1); slot_start <= 0; wt(3); chk(32'(HOE), 1);
    dflt <= 1; slot_start <= 3'h1; wt(1); slot_start <= 0; wt(3); chk(32'(HOE), 0);
    chk(32'(HOUT), 0);
  endtask
  initial begin
    wt(12);
    RESET <= 0;
    t_reg();
    t_id();
    t_safe();
    t_flag();
    t_wake();
    t_msel();
    t_out();
    report_and_stop();
  end
endmodule // test_wake_hwid_hv_io_pin_logic
`default_nettype wire
